// >>> src/aale_core.v
// Execution datapath for the add, relative jump and AND instruction group
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "aale_defs.vh"

module aale_core
(
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    // Instruction port from the decoder
    input wire instr_valid,
    input wire [15:0] instr_word,
    output reg instr_ready,
    // Flag set events from the core
    input wire sleep_event,
    input wire wdt_timeout_event,
    // Visible state
    output reg [7:0] w_reg,
    output reg [12:0] program_counter,
    output reg carry_flag,
    output reg half_carry_flag,
    output reg zero_flag,
    output reg power_down_flag,
    output reg watchdog_timeout_flag
);

    // ==========================================================
    // Declarations
    localparam [1:0] ST_IDLE = 2'b01; // Ready for a new word
    localparam [1:0] ST_JUMP = 2'b10; // Second cycle of a jump
    localparam [11:0] FILE_BASE = `AALE_FILE_BASE; // Byte address of location 00h

    reg [1:0] state; // Execution state
    reg [7:0] file_mem [0:`AALE_FILE_DEPTH-1]; // Data locations 00h to 7Fh
    reg [15:0] last_word; // Last word executed
    reg [15:0] bus_word; // Word queued by software
    reg bus_pend; // Software word waiting
    reg rd_pend; // Read data phase in progress
    reg wr_pend; // Write data phase in progress
    reg [11:0] ph_addr; // Latched address phase address
    reg [15:0] exec_word; // Word chosen for execution
    reg exec_go; // A word starts this cycle
    reg take_port; // Port word accepted this cycle
    reg [3:0] op; // Operation field
    reg dest; // Destination select
    reg [7:0] operand; // Literal or file address field
    reg [6:0] faddr; // File address
    reg [7:0] fdata; // File location content
    reg [7:0] addend; // Second adder input
    reg cin; // Adder carry in
    reg [8:0] sum9; // Full byte sum with carry out
    reg [4:0] sum5; // Low nibble sum with carry out
    reg [7:0] and8; // AND result
    reg [7:0] result; // Selected result
    reg is_add; // Addition group
    reg is_and; // AND group
    reg to_file; // Result goes to file
    reg [12:0] jump_target; // Target of relative jump
    reg [31:0] rd_mux; // Read data selection
    wire addr_take; // Address phase accepted
    wire bus_fhit_ph; // Latched address hits file window
    wire [6:0] bus_fidx_ph; // Latched file index

    // ==========================================================
    // Bus address decode
    assign addr_take = hsel & hready & htrans[1];
    assign bus_fidx_ph = ph_addr[8:2];
    // Window 200h to 3FCh, one location per word
    assign bus_fhit_ph = (ph_addr[11:9] == FILE_BASE[11:9]);

    // ==========================================================
    // Source select and instruction field split
    always @*
    begin
        take_port = instr_ready & instr_valid;
        exec_go = take_port | (instr_ready & bus_pend);
        // Port word wins over a queued software word
        exec_word = take_port ? instr_word : bus_word;
        // One 16-bit word carries op, destination and operand
        op = exec_word[`AALE_OP_HI:`AALE_OP_LO];
        dest = exec_word[`AALE_DEST_BIT];
        operand = exec_word[`AALE_OPERAND_HI:`AALE_OPERAND_LO];
        // Upper operand bit ignored, locations run to 7Fh
        faddr = operand[`AALE_FADDR_HI:0];
        fdata = file_mem[faddr];
    end

    // ==========================================================
    // Adder, AND unit and result routing
    always @*
    begin
        is_add = (op == `AALE_ADD_LITERAL_OP) | (op == `AALE_ADD_FILE_OP) |
                 (op == `AALE_ADD_FILE_CARRY_OP);
        is_and = (op == `AALE_AND_LITERAL_OP) | (op == `AALE_AND_FILE_OP);
        // Literal forms use the operand, file forms the location
        if ((op == `AALE_ADD_LITERAL_OP) | (op == `AALE_AND_LITERAL_OP))
        begin
            addend = operand;
        end
        else
        begin
            addend = fdata;
        end
        // Only add with carry feeds the carry flag in
        cin = (op == `AALE_ADD_FILE_CARRY_OP) ? carry_flag : 1'b0;
        sum9 = {1'b0, w_reg} + {1'b0, addend} + {8'h00, cin};
        sum5 = {1'b0, w_reg[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        and8 = w_reg & addend;
        result = is_and ? and8 : sum9[7:0];
        // File forms honour the destination bit, literal forms never
        to_file = dest & ((op == `AALE_ADD_FILE_OP) | (op == `AALE_ADD_FILE_CARRY_OP) |
                          (op == `AALE_AND_FILE_OP));
        // Signed offset: 7Fh forward, 80h and up backward
        jump_target = program_counter + 13'h0001 + {{5{w_reg[7]}}, w_reg};
    end

    // ==========================================================
    // Bus read data mux, unmapped addresses read zero
    always @*
    begin
        rd_mux = 32'h00000000;
        if (bus_fhit_ph)
        begin
            rd_mux = {24'h000000, file_mem[bus_fidx_ph]};
        end
        else
        begin
            case (ph_addr)
                `AALE_INSTR_OFFSET: rd_mux = {16'h0000, last_word};
                `AALE_WREG_OFFSET: rd_mux = {24'h000000, w_reg};
                `AALE_STATUS_OFFSET: rd_mux = {27'h0000000, watchdog_timeout_flag, power_down_flag,
                                              zero_flag, half_carry_flag, carry_flag};
                `AALE_PROG_COUNT_OFFSET: rd_mux = {19'h00000, program_counter};
                `AALE_STATE_OFFSET: rd_mux = {29'h00000000, bus_pend, state};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // Bus slave phases: reads take one wait state, writes none
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
            rd_pend <= 1'b0;
            wr_pend <= 1'b0;
            ph_addr <= 12'h000;
        end
        else
        begin
            hresp <= 1'b0;
            if (addr_take)
            begin
                // Latch address, stall read for the data mux flop
                ph_addr <= {haddr[11:2], 2'b00};
                rd_pend <= ~hwrite;
                wr_pend <= hwrite;
                hreadyout <= hwrite;
            end
            else if (rd_pend)
            begin
                // Read data lands with hreadyout high
                hrdata <= rd_mux;
                hreadyout <= 1'b1;
                rd_pend <= 1'b0;
            end
            else if (hreadyout)
            begin
                wr_pend <= 1'b0;
            end
            else
            begin
                hreadyout <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Execution state and visible state
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_IDLE;
            instr_ready <= 1'b1;
            w_reg <= `AALE_W_RESET;
            program_counter <= `AALE_PROG_COUNT_RESET;
            {watchdog_timeout_flag, power_down_flag, zero_flag, half_carry_flag, carry_flag}
                <= `AALE_STATUS_RESET;
            last_word <= `AALE_INSTR_RESET;
            bus_word <= `AALE_INSTR_RESET;
            bus_pend <= 1'b0;
        end
        else
        begin
            // Software register writes at the end of a write data phase
            if (wr_pend & hreadyout & ~bus_fhit_ph)
            begin
                case (ph_addr)
                    `AALE_INSTR_OFFSET:
                    begin
                        // Ignored while a queued word still waits
                        if (!bus_pend)
                        begin
                            bus_word <= hwdata[15:0];
                            bus_pend <= 1'b1;
                        end
                    end
                    `AALE_WREG_OFFSET: w_reg <= hwdata[7:0];
                    `AALE_STATUS_OFFSET:
                    begin
                        carry_flag <= hwdata[`AALE_CARRY_BIT];
                        half_carry_flag <= hwdata[`AALE_HALF_CARRY_BIT];
                        zero_flag <= hwdata[`AALE_ZERO_BIT];
                        power_down_flag <= hwdata[`AALE_POWER_DOWN_BIT];
                        watchdog_timeout_flag <= hwdata[`AALE_TIMEOUT_BIT];
                    end
                    `AALE_PROG_COUNT_OFFSET: program_counter <= hwdata[12:0];
                    default:
                    begin
                    end
                endcase
            end
            // Hardware events set, winning over a software clear
            if (sleep_event)
            begin
                power_down_flag <= 1'b1;
            end
            if (wdt_timeout_event)
            begin
                watchdog_timeout_flag <= 1'b1;
            end
            case (state)
                ST_IDLE:
                begin
                    if (exec_go)
                    begin
                        last_word <= exec_word;
                        if (!take_port)
                        begin
                            bus_pend <= 1'b0;
                        end
                        if (op == `AALE_RELATIVE_JUMP_OP)
                        begin
                            // Second cycle loads the target, flags untouched
                            state <= ST_JUMP;
                            instr_ready <= 1'b0;
                        end
                        else
                        begin
                            program_counter <= program_counter + 13'h0001;
                            if ((is_add | is_and) & ~to_file)
                            begin
                                w_reg <= result;
                            end
                            if (is_add | is_and)
                            begin
                                zero_flag <= (result == 8'h00);
                            end
                            if (is_add)
                            begin
                                carry_flag <= sum9[8];
                                half_carry_flag <= sum5[4];
                            end
                        end
                    end
                end
                ST_JUMP:
                begin
                    program_counter <= jump_target;
                    state <= ST_IDLE;
                    instr_ready <= 1'b1;
                end
                default:
                begin
                    state <= ST_IDLE;
                    instr_ready <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // File locations: execution write wins over a bus write
    always @(posedge hclk)
    begin
        if ((state == ST_IDLE) & exec_go & to_file & (is_add | is_and))
        begin
            file_mem[faddr] <= result;
        end
        else if (wr_pend & hreadyout & bus_fhit_ph)
        begin
            file_mem[bus_fidx_ph] <= hwdata[7:0];
        end
    end

endmodule // aale_core
`default_nettype wire

// >>> src/aale_defs.vh
// Constants for the add and logic execute block: opcodes, flags, register map
`ifndef AALE_DEFS_VH
`define AALE_DEFS_VH

// ==========================================================
// Instruction word layout (16-bit word)
`define AALE_OP_HI 15
`define AALE_OP_LO 12
`define AALE_DEST_BIT 8
`define AALE_OPERAND_HI 7
`define AALE_OPERAND_LO 0
`define AALE_FADDR_HI 6

// ==========================================================
// Operation codes in the op field
`define AALE_ADD_LITERAL_OP 4'h1
`define AALE_RELATIVE_JUMP_OP 4'h2
`define AALE_ADD_FILE_OP 4'h3
`define AALE_ADD_FILE_CARRY_OP 4'h4
`define AALE_AND_LITERAL_OP 4'h5
`define AALE_AND_FILE_OP 4'h6

// ==========================================================
// Status flag bit positions
`define AALE_CARRY_BIT 0
`define AALE_HALF_CARRY_BIT 1
`define AALE_ZERO_BIT 2
`define AALE_POWER_DOWN_BIT 3
`define AALE_TIMEOUT_BIT 4

// ==========================================================
// Reset values
`define AALE_W_RESET 8'h00
`define AALE_STATUS_RESET 5'h00
`define AALE_PROG_COUNT_RESET 13'h0000
`define AALE_INSTR_RESET 16'h0000

// ==========================================================
// Bus register byte offsets
`define AALE_INSTR_OFFSET 12'h000
`define AALE_WREG_OFFSET 12'h004
`define AALE_STATUS_OFFSET 12'h008
`define AALE_PROG_COUNT_OFFSET 12'h00C
`define AALE_STATE_OFFSET 12'h010
`define AALE_FILE_BASE 12'h200
`define AALE_FILE_DEPTH 128

// ==========================================================
// AHB-Lite encodings
`define AALE_HTRANS_NONSEQ 2'h2
`define AALE_HTRANS_SEQ 2'h3

`endif

// >>> test/aale_dec.sv
// Decoder model that offers instruction words to the execute block
`timescale 1ns/1ps
`default_nettype none
module aale_dec
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire logic [15:0] word_in,
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [15:0] instr_word,
    output logic done
);
    // ==========================================
    // Offer one whole word, hold it until taken
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            instr_valid <= 1'b0;
            instr_word <= 16'h0000;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            // Taken: drop the offer, scramble the idle word
            if (instr_valid && instr_ready)
            begin
                instr_valid <= 1'b0;
                instr_word <= ~instr_word;
                done <= 1'b1;
            end
            else if (go && !instr_valid)
            begin
                instr_valid <= 1'b1;
                instr_word <= word_in;
            end
        end
    end
endmodule // aale_dec
`default_nettype wire

// >>> test/aale_core_chk.sv
// Checker of the execute block's instruction port results
`timescale 1ns/1ps
`default_nettype none
`include "aale_defs.vh"
module aale_core_chk
(
    input wire hclk,
    input wire hresetn,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire instr_ready,
    input wire [7:0] w_reg,
    input wire [12:0] program_counter,
    input wire carry_flag,
    input wire half_carry_flag,
    input wire zero_flag
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================
    // Word taken last edge and state before it
    logic tk;
    logic [15:0] iw;
    logic [7:0] pw;
    logic [12:0] ppc;
    logic pcf;
    wire [3:0] op = iw[15:12];
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tk <= 1'b0;
            iw <= 16'h0000;
            pw <= 8'h00;
            ppc <= 13'h0000;
            pcf <= 1'b0;
        end
        else
        begin
            tk <= instr_valid && instr_ready;
            iw <= instr_word;
            pw <= w_reg;
            ppc <= program_counter;
            pcf <= carry_flag;
        end
    end
    // ==========================================
    // Assertions
    sequence s_take(logic [3:0] o);
        instr_valid && instr_ready && instr_word[15:12] == o;
    endsequence
    property p_jump;
        logic [12:0] t;
        (s_take(`AALE_RELATIVE_JUMP_OP), t = program_counter + 13'h1 + {{5{w_reg[7]}}, w_reg})
        |=> !instr_ready ##1 (instr_ready && program_counter == t);
    endproperty
    a_lit_add_sum: assert property (tk && op == 4'h1 |-> {carry_flag, w_reg} == pw + iw[7:0])
        else $error("add literal sum wrong");
    a_lit_half_carry: assert property (tk && op == 4'h1 |-> half_carry_flag == (pw[3:0] + iw[3:0] > 15))
        else $error("half carry wrong");
    a_zero_result: assert property (tk && (op == 4'h1 || op == 4'h5) |-> zero_flag == (w_reg == 8'h00))
        else $error("zero flag wrong");
    a_and_lit: assert property (tk && op == 4'h5 |-> w_reg == (pw & iw[7:0]) && carry_flag == pcf)
        else $error("and literal wrong");
    a_jump_target: assert property (p_jump)
        else $error("jump target wrong");
    a_jump_flags: assert property (s_take(4'h2) |=> $stable({carry_flag, half_carry_flag, zero_flag})[*2])
        else $error("jump changed flags");
    a_file_dest: assert property (tk && op >= 4'h3 && op != 4'h5 && op <= 4'h6 && iw[8] |-> w_reg == pw)
        else $error("file destination wrote W");
    a_pc_step: assert property (tk && op != 4'h2 |-> program_counter == ppc + 13'h1 && instr_ready)
        else $error("one word step wrong");
endmodule // aale_core_chk
bind aale_core aale_core_chk u_chk (.hclk(hclk), .hresetn(hresetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .w_reg(w_reg), .program_counter(program_counter),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .zero_flag(zero_flag));
`default_nettype wire

// >>> test/tb.sv
// Testbench for the add and logic execute block
`timescale 1ns/1ps
`default_nettype none
`include "aale_defs.vh"
module tb;
    // ==========================================
    // Drive, observe, count
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic go = 1'b0;
    logic slp = 1'b0;
    logic wdt = 1'b0;
    logic [15:0] word_in = 16'h0000;
    logic [31:0] rd;
    wire hreadyout, hresp, instr_valid, instr_ready, done, cf, hcf, zf, pdf, tof;
    wire [31:0] hrdata;
    wire [15:0] instr_word;
    wire [7:0] w_reg;
    wire [12:0] program_counter;
    integer fails = 0;
    integer n_checks = 0;
    always #5 hclk = ~hclk;
    aale_core u_aale_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .sleep_event(slp), .wdt_timeout_event(wdt), .w_reg(w_reg),
        .program_counter(program_counter), .carry_flag(cf), .half_carry_flag(hcf), .zero_flag(zf),
        .power_down_flag(pdf), .watchdog_timeout_flag(tof));
    aale_dec u_aale_dec (.hclk(hclk), .hresetn(hresetn), .go(go), .word_in(word_in),
        .instr_ready(instr_ready), .instr_valid(instr_valid), .instr_word(instr_word), .done(done));
    // ==========================================
    // Shared tasks
    task test_done;
    begin
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
    begin
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    // Bounded wait on ready (k=0) or decoder done (k=1)
    task wt(input integer k);
        integer i;
    begin
        i = 0;
        @(posedge hclk);
        while ((k ? done : hreadyout) !== 1'b1)
        begin
            i++;
            if (i > 50)
            begin
                fails++;
                test_done;
            end
            @(posedge hclk);
        end
    end
    endtask
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    begin
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= `AALE_HTRANS_NONSEQ;
        wt(0);
        htrans <= 2'h0;
        hwdata <= d;
        wt(0);
        rd = hrdata;
    end
    endtask
    task ex(input logic [15:0] w);
    begin
        go <= 1'b1;
        word_in <= w;
        @(posedge hclk);
        go <= 1'b0;
        wt(1);
        @(posedge hclk);
    end
    endtask
    // ==========================================
    // Scenarios
    task t_lit;
    begin
        chk({cf, hcf, zf, pdf, tof, w_reg, program_counter}, 32'h0);
        bus(1, `AALE_WREG_OFFSET, 32'h08);
        ex({`AALE_ADD_LITERAL_OP, 4'h0, 8'h08});
        chk({cf, hcf, zf, w_reg}, {3'h2, 8'h10});
        ex({`AALE_ADD_LITERAL_OP, 4'h1, 8'hF0});
        chk({cf, hcf, zf, w_reg}, {3'h5, 8'h00});
        $display("test lit end");
    end
    endtask
    logic [7:0] jw [0:2] = '{8'h7F, 8'h80, 8'hFE};
    logic [12:0] jp [0:2] = '{13'h0292, 13'h0193, 13'h0211};
    task t_jump;
        integer i;
    begin
        for (i = 0; i < 3; i++)
        begin
            bus(1, `AALE_STATUS_OFFSET, 32'h7);
            bus(1, `AALE_PROG_COUNT_OFFSET, 32'h212);
            bus(1, `AALE_WREG_OFFSET, jw[i]);
            ex({`AALE_RELATIVE_JUMP_OP, 12'h000});
            chk({19'h00000, program_counter}, {19'h00000, jp[i]});
            chk({cf, hcf, zf}, 3'h7);
        end
        $display("test jump end");
    end
    endtask
    task t_file;
    begin
        bus(1, 12'h314, 32'hC2);
        bus(1, `AALE_WREG_OFFSET, 32'h17);
        ex({`AALE_ADD_FILE_OP, 4'h0, 8'hC5});
        chk({cf, hcf, zf, w_reg}, {3'h0, 8'hD9});
        ex({`AALE_ADD_FILE_OP, 4'h1, 8'h45});
        chk({cf, hcf, zf, w_reg}, {3'h4, 8'hD9});
        bus(0, 12'h314, 32'h0);
        chk(rd, 32'h9B);
        $display("test file end");
    end
    endtask
    task t_carry;
    begin
        bus(1, `AALE_STATUS_OFFSET, 32'h1);
        bus(1, 12'h240, 32'h02);
        bus(1, `AALE_WREG_OFFSET, 32'h4D);
        ex({`AALE_ADD_FILE_CARRY_OP, 4'h1, 8'h10});
        chk({cf, hcf, zf, w_reg}, {3'h2, 8'h4D});
        bus(0, 12'h240, 32'h0);
        chk(rd, 32'h50);
        ex({`AALE_ADD_FILE_CARRY_OP, 4'h0, 8'h10});
        chk({cf, hcf, zf, w_reg}, {3'h0, 8'h9D});
        $display("test carry end");
    end
    endtask
    task t_and;
    begin
        bus(1, `AALE_STATUS_OFFSET, 32'h7);
        bus(1, `AALE_WREG_OFFSET, 32'hA3);
        ex({`AALE_AND_LITERAL_OP, 4'h0, 8'h5F});
        chk({cf, hcf, zf, w_reg}, {3'h6, 8'h03});
        bus(1, 12'h3FC, 32'h88);
        bus(1, `AALE_WREG_OFFSET, 32'h0F);
        ex({`AALE_AND_FILE_OP, 4'h0, 8'h7F});
        chk({cf, hcf, zf, w_reg}, {3'h6, 8'h08});
        bus(1, `AALE_WREG_OFFSET, 32'h0F);
        ex({`AALE_AND_FILE_OP, 4'h1, 8'h7F});
        bus(0, 12'h3FC, 32'h0);
        chk(rd, 32'h00000008);
        chk({24'h000000, w_reg}, 32'h0000000F);
        ex({`AALE_AND_LITERAL_OP, 4'h0, 8'h00});
        chk({cf, hcf, zf, w_reg}, {3'h7, 8'h00});
        $display("test and end");
    end
    endtask
    task t_flags;
    begin
        bus(1, `AALE_STATUS_OFFSET, 32'h0);
        slp <= 1'b1;
        @(posedge hclk);
        slp <= 1'b0;
        wdt <= 1'b1;
        @(posedge hclk);
        wdt <= 1'b0;
        bus(0, `AALE_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h18);
        bus(1, `AALE_STATUS_OFFSET, 32'h0);
        // The clear lands at the edge the bus task returns on
        @(posedge hclk);
        chk({pdf, tof}, 2'h0);
        // Event and software clear in one cycle: the event wins
        slp <= 1'b1;
        bus(1, `AALE_STATUS_OFFSET, 32'h0);
        slp <= 1'b0;
        @(posedge hclk);
        chk({pdf, tof}, 2'h2);
        bus(0, 12'h100, 32'h0);
        chk(rd, 32'h0);
        chk({31'h00000000, hresp}, 32'h0);
        $display("test flags end");
    end
    endtask
    // Word queued by software runs once the port is idle
    task t_queue;
    begin
        bus(1, `AALE_WREG_OFFSET, 32'h21);
        bus(1, `AALE_INSTR_OFFSET, {16'h0000, `AALE_ADD_LITERAL_OP, 4'h0, 8'h12});
        bus(0, `AALE_STATE_OFFSET, 32'h0);
        chk(rd, 32'h00000001);
        chk({21'h000000, cf, hcf, zf, w_reg}, {21'h000000, 3'h0, 8'h33});
        bus(0, `AALE_INSTR_OFFSET, 32'h0);
        chk(rd, 32'h00001012);
        $display("test queue end");
    end
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_lit;
        t_jump;
        t_file;
        t_carry;
        t_and;
        t_flags;
        t_queue;
        test_done;
    end
endmodule // tb
`default_nettype wire
